/* shared/monitor_pkg.sv */
// Constants and types shared by the event monitor counter block
package monitor_pkg;

  // Register map, byte addresses on the 64-bit register port
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] COUNTS_OFFSET = 8'h08;

  // Control field positions
  localparam int SELECT_A_LSB = 0;
  localparam int SELECT_B_LSB = 8;
  localparam int SELECT_W = 8;
  localparam int WRAP_A_BIT = 16;
  localparam int WRAP_B_BIT = 17;
  localparam int CTRL_USED_W = 18;

  // Count field positions
  localparam int COUNT_A_LSB = 0;
  localparam int COUNT_B_LSB = 32;

  // Select codes of the shared signal set
  localparam logic [7:0] SEL_ZERO = 8'h00;
  // Revision marker code, value arbitrary
  localparam logic [7:0] SEL_REVISION = 8'h03;
  localparam logic [7:0] SEL_PROBE_BASE = 8'h10;
  localparam logic [7:0] SEL_GATED_BASE = 8'h20;
  localparam logic [7:0] SEL_CARRY_A = 8'h30;
  localparam logic [7:0] SEL_CARRY_B = 8'h31;
  localparam int SIGNAL_SET_W = 64;

  // Reset values
  localparam logic [7:0] SELECT_A_RESET = SEL_REVISION;
  localparam logic [7:0] SELECT_B_RESET = 8'h00;
  localparam logic WRAP_RESET = 1'b0;
  // Revision marker level, value arbitrary
  localparam logic REVISION_MARK = 1'b1;

  // Cycle counts
  localparam int MONITOR_DELAY = 2;
  localparam int HOLD_CYCLES = 4;
  localparam logic [2:0] HOLD_LOAD = 3'(HOLD_CYCLES);

endpackage : monitor_pkg

/* shared/counter_if.sv */
// Control and status of one event counter
`timescale 1ns/1ps
interface counter_if #(parameter int COUNT_W = 32) ();
  logic inc;
  logic clear;
  logic hold;
  logic wrap;
  logic [COUNT_W-1:0] value;
  logic carry;
  modport ctrl (output inc, output clear, output hold, output wrap, input value, input carry);
  modport cnt (input inc, input clear, input hold, input wrap, output value, output carry);
endinterface : counter_if

/* rtl/event_counter.sv */
// One saturating or wrapping event counter
`timescale 1ns/1ps
module event_counter
  import monitor_pkg::*;
#(
  parameter int COUNT_W = 32
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  counter_if.cnt ctl
);

  logic [COUNT_W-1:0] value_reg;
  logic carry_reg;
  logic at_top;

  // Width check at elaboration
  if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_width
    $error("event_counter: COUNT_W out of range");
  end

  assign at_top = &value_reg;
  assign ctl.value = value_reg;
  assign ctl.carry = carry_reg;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      value_reg <= '0;
    end else if (ctl.clear) begin
      value_reg <= '0;
    end else if (ctl.hold) begin
      value_reg <= value_reg;
    end else if (ctl.inc) begin
      if (at_top && !ctl.wrap) begin
        value_reg <= value_reg;
      end else begin
        value_reg <= value_reg + COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      carry_reg <= 1'b0;
    end else begin
      carry_reg <= ctl.inc && !ctl.hold && !ctl.clear && at_top && ctl.wrap;
    end
  end

  property p_stick;
    @(posedge CLK) disable iff (SYS_RST)
    (at_top && !ctl.wrap && !ctl.clear) |=> (&value_reg);
  endproperty
  a_stick: assert property (p_stick) else $error("counter left all ones in stick mode");

  property p_wrap;
    @(posedge CLK) disable iff (SYS_RST)
    (at_top && ctl.wrap && ctl.inc && !ctl.hold && !ctl.clear) |=> (value_reg == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

  property p_step;
    @(posedge CLK) disable iff (SYS_RST)
    (ctl.inc && !ctl.hold && !ctl.clear && !at_top) |=>
      (value_reg == $past(value_reg) + COUNT_W'(1));
  endproperty
  a_step: assert property (p_step) else $error("counter missed an asserted cycle");

  property p_freeze;
    @(posedge CLK) disable iff (SYS_RST)
    (ctl.hold && !ctl.clear) |=> $stable(value_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while held");

endmodule // event_counter

/* rtl/event_monitor_counters.sv */
// Monitor select, output pipeline and paired event counters
//
// Contract
// - Two select fields, bits 7:0 and 15:8, pick monitor outputs zero and one.
// - Each monitor output shows its selected signal exactly two clocks later.
// - All selectable signals are synchronized to the system clock first.
// - Some probe signals are gated by the delayed PCI cycle pulse.
// - Monitor output zero counts the low field, output one the high field.
// - Counters add one per clock with their monitor signal asserted.
// - Any write to the control register clears both counters.
// - Counters stick at all ones by default.
// - Control bits 16 and 17 select wrap instead of stick per counter.
// - One counter's carry can be selected as the other's input.
// - Reading the counts freezes both counters for four cycles.
// - Select A resets to the revision marker; others reset to zero.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module event_monitor_counters
  import monitor_pkg::*;
#(
  parameter int NUM_PROBES = 8,
  parameter int COUNT_W = 32
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] ADDR,
  input wire logic [63:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [63:0] RD_DATA,
  input wire logic [NUM_PROBES-1:0] PROBE_IN,
  input wire logic PCI_CYCLE_PULSE,
  output logic [1:0] MONITOR_OUT
);

  // Parameter checks at elaboration
  if (NUM_PROBES < 1 || NUM_PROBES > 16) begin : g_bad_probes
    $error("event_monitor_counters: NUM_PROBES out of range");
  end
  if (COUNT_W != 32) begin : g_bad_count_w
    $error("event_monitor_counters: COUNT_W must be 32");
  end

  logic [7:0] probe_select_a_reg;
  logic [7:0] probe_select_b_reg;
  logic wrap_enable_a_reg;
  logic wrap_enable_b_reg;
  logic [NUM_PROBES-1:0] probe_sync1_reg;
  logic [NUM_PROBES-1:0] probe_sync2_reg;
  logic pci_cycle_pulse_delayed_reg;
  logic [SIGNAL_SET_W-1:0] signal_set;
  logic [1:0] mon_stage_reg;
  logic sel_a;
  logic sel_b;
  logic [2:0] hold_cnt_reg;
  logic counts_hold;
  logic ctrl_write;
  logic counts_read;
  logic [63:0] rd_data_next;
  logic [COUNT_W-1:0] event_count_a;
  logic [COUNT_W-1:0] event_count_b;
  logic carry_a;
  logic carry_b;

  counter_if #(.COUNT_W(COUNT_W)) cif[2] ();

  // Pick one member of the signal set
  function automatic logic pick(input logic [7:0] sel, input logic [SIGNAL_SET_W-1:0] set);
    logic bit_out;
    bit_out = 1'b0;
    if (sel < 8'(SIGNAL_SET_W)) begin
      bit_out = set[sel[5:0]];
    end
    return bit_out;
  endfunction

  assign ctrl_write = WR_STB && (ADDR == CTRL_OFFSET);
  assign counts_read = RD_STB && (ADDR == COUNTS_OFFSET);

  // Control register
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      probe_select_a_reg <= SELECT_A_RESET;
      probe_select_b_reg <= SELECT_B_RESET;
      wrap_enable_a_reg <= WRAP_RESET;
      wrap_enable_b_reg <= WRAP_RESET;
    end else if (ctrl_write) begin
      probe_select_a_reg <= WR_DATA[SELECT_A_LSB +: SELECT_W];
      probe_select_b_reg <= WR_DATA[SELECT_B_LSB +: SELECT_W];
      wrap_enable_a_reg <= WR_DATA[WRAP_A_BIT];
      wrap_enable_b_reg <= WR_DATA[WRAP_B_BIT];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      probe_sync1_reg <= '0;
      probe_sync2_reg <= '0;
    end else begin
      probe_sync1_reg <= PROBE_IN;
      probe_sync2_reg <= probe_sync1_reg;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pci_cycle_pulse_delayed_reg <= 1'b0;
    end else begin
      pci_cycle_pulse_delayed_reg <= PCI_CYCLE_PULSE;
    end
  end

  // Shared signal set
  always_comb begin
    signal_set = '0;
    signal_set[SEL_ZERO[5:0]] = 1'b0;
    signal_set[SEL_REVISION[5:0]] = REVISION_MARK;
    for (int i = 0; i < NUM_PROBES; i++) begin
      signal_set[SEL_PROBE_BASE[5:0] + 6'(i)] = probe_sync2_reg[i];
      signal_set[SEL_GATED_BASE[5:0] + 6'(i)] = probe_sync2_reg[i] && pci_cycle_pulse_delayed_reg;
    end
    signal_set[SEL_CARRY_A[5:0]] = carry_a;
    signal_set[SEL_CARRY_B[5:0]] = carry_b;
  end

  assign sel_a = pick(probe_select_a_reg, signal_set);
  assign sel_b = pick(probe_select_b_reg, signal_set);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mon_stage_reg <= 2'h0;
      MONITOR_OUT <= 2'h0;
    end else begin
      mon_stage_reg <= {sel_b, sel_a};
      MONITOR_OUT <= mon_stage_reg;
    end
  end

  // Hold window after a counts read
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hold_cnt_reg <= 3'h0;
    end else if (counts_read) begin
      hold_cnt_reg <= HOLD_LOAD;
    end else if (hold_cnt_reg != 3'h0) begin
      hold_cnt_reg <= hold_cnt_reg - 3'h1;
    end
  end

  assign counts_hold = (hold_cnt_reg != 3'h0);

  // Counter control
  // Monitor outputs feed counters
  assign cif[0].inc = MONITOR_OUT[0];
  assign cif[1].inc = MONITOR_OUT[1];
  assign cif[0].wrap = wrap_enable_a_reg;
  assign cif[1].wrap = wrap_enable_b_reg;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_cnt
      assign cif[g].clear = ctrl_write;
      assign cif[g].hold = counts_hold;
      event_counter #(.COUNT_W(COUNT_W)) u_cnt (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .ctl(cif[g])
      );
    end
  endgenerate

  assign event_count_a = cif[0].value;
  assign event_count_b = cif[1].value;
  assign carry_a = cif[0].carry;
  assign carry_b = cif[1].carry;

  // Read decode
  always_comb begin
    rd_data_next = 64'h0;
    if (ADDR == CTRL_OFFSET) begin
      rd_data_next[SELECT_A_LSB +: SELECT_W] = probe_select_a_reg;
      rd_data_next[SELECT_B_LSB +: SELECT_W] = probe_select_b_reg;
      rd_data_next[WRAP_A_BIT] = wrap_enable_a_reg;
      rd_data_next[WRAP_B_BIT] = wrap_enable_b_reg;
    end else if (ADDR == COUNTS_OFFSET) begin
      rd_data_next[COUNT_A_LSB +: 32] = event_count_a;
      rd_data_next[COUNT_B_LSB +: 32] = event_count_b;
    end
  end

  // Read data register, one cycle only
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_DATA <= 64'h0;
    end else if (RD_STB) begin
      RD_DATA <= rd_data_next;
    end else begin
      RD_DATA <= 64'h0;
    end
  end

  // Checks
  property p_delay_a;
    @(posedge CLK) disable iff (SYS_RST)
    !$past(SYS_RST) |-> ##2 (MONITOR_OUT[0] == $past(sel_a, 2));
  endproperty
  a_delay_a: assert property (p_delay_a) else $error("monitor zero not two cycles late");

  property p_delay_b;
    @(posedge CLK) disable iff (SYS_RST)
    !$past(SYS_RST) |-> ##2 (MONITOR_OUT[1] == $past(sel_b, 2));
  endproperty
  a_delay_b: assert property (p_delay_b) else $error("monitor one not two cycles late");

  property p_clear;
    @(posedge CLK) disable iff (SYS_RST)
    ctrl_write |=> (event_count_a == '0) && (event_count_b == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("control write did not clear counts");

  sequence s_counts_read;
    counts_read;
  endsequence

  sequence s_hold_window;
    counts_hold [*4];
  endsequence

  property p_hold;
    @(posedge CLK) disable iff (SYS_RST)
    s_counts_read |=> s_hold_window;
  endproperty
  a_hold: assert property (p_hold) else $error("hold window not four cycles");

  sequence s_quiet;
    (!counts_read) [*4];
  endsequence

  property p_hold_end;
    @(posedge CLK) disable iff (SYS_RST)
    s_counts_read ##1 s_quiet |=> !counts_hold;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold window outlasted four cycles");

  property p_gated;
    @(posedge CLK) disable iff (SYS_RST)
    ((probe_select_a_reg >= SEL_GATED_BASE) &&
      (probe_select_a_reg < SEL_GATED_BASE + 8'(NUM_PROBES)) && sel_a) |->
      pci_cycle_pulse_delayed_reg;
  endproperty
  a_gated: assert property (p_gated) else $error("gated probe passed without pulse");

  property p_cascade;
    @(posedge CLK) disable iff (SYS_RST)
    ((probe_select_b_reg == SEL_CARRY_A) && carry_a && !ctrl_write) |=> ##1 MONITOR_OUT[1];
  endproperty
  a_cascade: assert property (p_cascade) else $error("carry did not reach monitor one");

  property p_reserved;
    @(posedge CLK) disable iff (SYS_RST)
    (RD_STB && ADDR == CTRL_OFFSET) |=> (RD_DATA[63:CTRL_USED_W] == '0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved control bits not zero");

  property p_count_ro;
    @(posedge CLK) disable iff (SYS_RST)
    (WR_STB && ADDR == COUNTS_OFFSET && !MONITOR_OUT[0] && !MONITOR_OUT[1]) |=>
      ($stable(event_count_a) && $stable(event_count_b));
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count write changed counter");

  property p_feed;
    @(posedge CLK) disable iff (SYS_RST)
    (MONITOR_OUT[0] && !counts_hold && !ctrl_write && !(&event_count_a)) |=>
      (event_count_a == $past(event_count_a) + 32'h1);
  endproperty
  a_feed: assert property (p_feed) else $error("monitor zero not counted");

  property p_feed_b;
    @(posedge CLK) disable iff (SYS_RST)
    (MONITOR_OUT[1] && !counts_hold && !ctrl_write && !(&event_count_b)) |=>
      (event_count_b == $past(event_count_b) + 32'h1);
  endproperty
  a_feed_b: assert property (p_feed_b) else $error("monitor one not counted");

  property p_unmapped;
    @(posedge CLK) disable iff (SYS_RST)
    (RD_STB && (ADDR != CTRL_OFFSET) && (ADDR != COUNTS_OFFSET)) |=> (RD_DATA == 64'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_rd_counts;
    @(posedge CLK) disable iff (SYS_RST)
    counts_read |=> (RD_DATA == {$past(event_count_b), $past(event_count_a)});
  endproperty
  a_rd_counts: assert property (p_rd_counts) else $error("count fields misplaced");

endmodule // event_monitor_counters

/* dv/tb.sv */
// Self-checking bench for the event monitor counter block
`timescale 1ns/1ps
module tb
  import monitor_pkg::*;
;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [63:0] WR_DATA = 64'h0;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic [63:0] RD_DATA;
  logic [7:0] PROBE_IN = 8'h00;
  logic PCI_CYCLE_PULSE = 1'b0;
  logic [1:0] MONITOR_OUT;
  logic [7:0] p1, p2, p3, p4, v;
  logic [63:0] rd, v0;
  int n_errors = 0;
  int samples_checked = 0;
  int ia, ib, exp_a, exp_b, n;

  always #20 CLK = ~CLK;

  event_monitor_counters #(.NUM_PROBES(8), .COUNT_W(32)) dut (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .ADDR(ADDR),
    .WR_DATA(WR_DATA),
    .WR_STB(WR_STB),
    .RD_STB(RD_STB),
    .RD_DATA(RD_DATA),
    .PROBE_IN(PROBE_IN),
    .PCI_CYCLE_PULSE(PCI_CYCLE_PULSE),
    .MONITOR_OUT(MONITOR_OUT)
  );

  // Probe history for the expected monitor level
  always @(posedge CLK) begin
    p1 <= PROBE_IN;
    p2 <= p1;
    p3 <= p2;
    p4 <= p3;
  end

  function automatic logic [63:0] ctl(input logic [7:0] a, input logic [7:0] b);
    return {48'h0, b, a};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_mon(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED monitor t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK);
    WR_STB <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    #1;
    rd = RD_DATA;
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(74491));
    repeat (20) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd_reg(CTRL_OFFSET);
    check(rd, ctl(SELECT_A_RESET, 8'h00));
    check_mon(MONITOR_OUT, {1'b0, REVISION_MARK});
    wr(CTRL_OFFSET, '1);
    rd_reg(CTRL_OFFSET);
    check(rd, 64'h3FFFF);
    rd_reg(8'h10);
    check(rd, 64'h0);
    // Random probe traffic on both outputs
    for (int r = 0; r < 3; r++) begin
      ia = $urandom_range(7);
      ib = $urandom_range(7);
      PROBE_IN <= 8'h00;
      repeat (6) @(posedge CLK);
      wr(CTRL_OFFSET, ctl(SEL_PROBE_BASE + 8'(ia), SEL_PROBE_BASE + 8'(ib)));
      rd_reg(CTRL_OFFSET);
      check(rd, ctl(SEL_PROBE_BASE + 8'(ia), SEL_PROBE_BASE + 8'(ib)));
      exp_a = 0;
      exp_b = 0;
      repeat (200) begin
        @(posedge CLK);
        v = 8'($urandom);
        PROBE_IN <= v;
        exp_a += v[ia];
        exp_b += v[ib];
        #1;
        check_mon(MONITOR_OUT, {p4[ib], p4[ia]});
      end
      @(posedge CLK);
      PROBE_IN <= 8'h00;
      repeat (8) @(posedge CLK);
      rd_reg(COUNTS_OFFSET);
      check(rd, {32'(exp_b), 32'(exp_a)});
      wr(COUNTS_OFFSET, '1);
      rd_reg(COUNTS_OFFSET);
      check(rd, {32'(exp_b), 32'(exp_a)});
      wr(CTRL_OFFSET, 64'h0);
      rd_reg(COUNTS_OFFSET);
      check(rd, 64'h0);
    end
    // Freeze after a counts read
    wr(CTRL_OFFSET, ctl(SEL_PROBE_BASE, SEL_PROBE_BASE + 8'h01));
    PROBE_IN <= 8'hFF;
    repeat (6) @(posedge CLK);
    rd_reg(COUNTS_OFFSET);
    v0 = rd;
    repeat (8) @(posedge CLK);
    rd_reg(COUNTS_OFFSET);
    check(rd, v0 + {32'd6, 32'd6});
    // Gated probes count PCI pulses only
    PROBE_IN <= 8'h00;
    repeat (6) @(posedge CLK);
    wr(CTRL_OFFSET, ctl(SEL_GATED_BASE + 8'(ia), SEL_GATED_BASE + 8'(ib)));
    PROBE_IN <= 8'hFF;
    repeat (6) @(posedge CLK);
    n = $urandom_range(20, 5);
    repeat (n) begin
      @(posedge CLK);
      PCI_CYCLE_PULSE <= 1'b1;
      @(posedge CLK);
      PCI_CYCLE_PULSE <= 1'b0;
      @(posedge CLK);
    end
    repeat (8) @(posedge CLK);
    rd_reg(COUNTS_OFFSET);
    check(rd, {32'(n), 32'(n)});
    print_verdict();
  end
endmodule // tb
